/* File: acs_defs.vh */
/*
 * Constants for the calibration configuration and status block:
 * register indices, APB byte addresses, reset values and field positions.
 * Assumes it is included by its bare name from the block's design files.
 */
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH

// Register indices; the APB byte address is four times the index
`define ACS_IDX_CFG0 8'h62
`define ACS_IDX_CFG1 8'h65
`define ACS_IDX_AVG 8'h68
`define ACS_IDX_STATUS 8'h6a
`define ACS_IDX_PIN 8'h6b
`define ACS_IDX_SOFT 8'h6c
`define ACS_IDX_IRQ_STAT 8'h70
`define ACS_IDX_IRQ_MASK 8'h71

// APB address width and byte addresses
`define ACS_AW 12
`define ACS_ADDR_CFG0 {2'b00, `ACS_IDX_CFG0, 2'b00}
`define ACS_ADDR_CFG1 {2'b00, `ACS_IDX_CFG1, 2'b00}
`define ACS_ADDR_AVG {2'b00, `ACS_IDX_AVG, 2'b00}
`define ACS_ADDR_STATUS {2'b00, `ACS_IDX_STATUS, 2'b00}
`define ACS_ADDR_PIN {2'b00, `ACS_IDX_PIN, 2'b00}
`define ACS_ADDR_SOFT {2'b00, `ACS_IDX_SOFT, 2'b00}
`define ACS_ADDR_IRQ_STAT {2'b00, `ACS_IDX_IRQ_STAT, 2'b00}
`define ACS_ADDR_IRQ_MASK {2'b00, `ACS_IDX_IRQ_MASK, 2'b00}

// Reset values
`define ACS_RST_CFG0 8'h01
`define ACS_RST_CFG1 8'h01
`define ACS_RST_AVG 8'h61
`define ACS_RST_PIN 8'h00
`define ACS_RST_SOFT 8'h01
`define ACS_RST_IRQ 3'h0

// Field positions
`define ACS_BIT_BG_EN 1
`define ACS_BIT_OFFSET_REFERENCE_SELECT 2
`define ACS_OFFSET_AVERAGE_DEPTH_HI 6
`define ACS_OFFSET_AVERAGE_DEPTH_LO 4
`define ACS_LIN_AVG_HI 2
`define ACS_LIN_AVG_LO 0
`define ACS_SEL_HI 2
`define ACS_SEL_LO 1
`define ACS_BIT_TRIG_SEL 0
`define ACS_BIT_SOFT_TRIG 0
`define ACS_BIT_FOREGROUND_COMPLETE_FLAG 0
`define ACS_BIT_HALTED 1
`define ACS_STATE_HI 4
`define ACS_STATE_LO 2

// Interrupt status bits
`define ACS_IRQ_FG 0
`define ACS_IRQ_HALT 1
`define ACS_IRQ_ALARM 2

// Status pin source codes
`define ACS_SEL_FG 2'h0
`define ACS_SEL_HALT 2'h1
`define ACS_SEL_ALARM 2'h2
`define ACS_SEL_LOW 2'h3

`endif

/* File: acs_sync.v */
/*
 * Two flip-flop synchroniser for levels entering from outside the clock domain.
 * Assumes the input is a slow level, held for well over two clock periods.
 */
`timescale 1ns/10ps
`default_nettype none

module acs_sync #(
   parameter WIDTH = 1
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);

   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   // First stage is read only by the second stage
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
      end
      else
      begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule // acs_sync

`default_nettype wire

/* File: acs_top.v */
/*
 * Calibration configuration and status block: APB register file holding the
 * offset reference choice, averaging depths, background enable, trigger
 * source and status pin source, plus the read-only status flags and a
 * sticky interrupt. Assumes the calibration engine runs on CLK_I and gives
 * one-cycle event pulses; the trigger pin is asynchronous.
 */
// The implementer's own choice: the APB slave port.
// Contract
// - Offset reference select at 0 makes the engine calibrate to mid-code.
// - Offset reference select at 1 makes the engine use the spare converter.
// - Offset averaging depth is bits 6:4, reset 0x6, larger means more.
// - Linearity averaging depth is bits 2:0, reset 0x1, larger means more.
// - Status register is read-only, calibration state code in bits 4:2.
// - Halted flag sets when background stops, clears when calibration resumes.
// - With background off, halted flag sets when foreground finishes or skips.
// - Foreground-complete flag is high once foreground finished or was skipped.
// - Pin setup register resets to zero: reserved, pin source, trigger source.
// - Status pin source: 0 complete, 1 halted, 2 alarm, 3 low.
// - Trigger source 0 uses software bit, 1 uses the trigger pin.
// - Background enable bit: 1 enables background calibration, reset 0.
`timescale 1ns/10ps
`default_nettype none
`include "acs_defs.vh"

module acs_top (
   input wire CLK_I,
   input wire RST_N_I,
   input wire PSEL_I,
   input wire PENABLE_I,
   input wire PWRITE_I,
   input wire [`ACS_AW-1:0] PADDR_I,
   input wire [31:0] PWDATA_I,
   input wire [3:0] PSTRB_I,
   output wire [31:0] PRDATA_O,
   output wire PREADY_O,
   output wire PSLVERR_O,
   input wire FG_START_I,
   input wire FOREGROUND_COMPLETE_FLAG_I,
   input wire BG_STOPPED_I,
   input wire BG_RESUMED_I,
   input wire [2:0] CAL_STATE_I,
   input wire ALARM_I,
   input wire TRIGGER_INPUT_PIN_I,
   output wire OFFSET_REFERENCE_SELECT_O,
   output wire [2:0] OFFSET_AVERAGE_DEPTH_O,
   output wire [2:0] LINEARITY_AVERAGE_DEPTH_O,
   output wire BACKGROUND_CAL_ENABLE_O,
   output wire CAL_TRIGGER_O,
   output wire STATUS_OUTPUT_PIN_O,
   output wire IRQ_O
);

   // Register storage
   reg [7:0] cfg0_q;
   reg [7:0] cfg1_q;
   reg [7:0] avg_q;
   reg [7:0] pin_q;
   reg [7:0] soft_q;
   reg [2:0] irq_stat_q;
   reg [2:0] irq_stat_d;
   reg [2:0] irq_mask_q;

   // Status flags
   reg foreground_complete_flag_q;
   reg foreground_complete_flag_d;
   reg halted_q;
   reg halted_d;
   reg [2:0] state_q;
   reg alarm_q;

   // APB answer
   reg pready_q;
   reg pslverr_q;
   reg [31:0] prdata_q;
   reg [7:0] rdata_d;
   reg hit_d;

   // Registered outputs
   reg status_pin_q;
   reg trigger_q;
   reg irq_q;

   wire trig_pin_sync;
   wire access;
   wire wr_en;
   wire wr_lane;
   wire bg_en;
   wire fg_set;
   wire halt_set;
   wire alarm_rise;
   wire [2:0] irq_evt;

   // Trigger pin comes from outside the clock domain
   acs_sync #(
      .WIDTH(1)
   ) u_trig_sync (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .async_i(TRIGGER_INPUT_PIN_I),
      .sync_o(trig_pin_sync)
   );

   // A write lands only at the completing edge of the access phase
   assign access = PSEL_I & PENABLE_I & pready_q;
   assign wr_lane = PSTRB_I[0];
   assign wr_en = access & PWRITE_I & wr_lane & hit_d;
   assign bg_en = cfg0_q[`ACS_BIT_BG_EN];

   // Address decode and read mux; status register is read-only
   always @*
   begin
      rdata_d = 8'h00;
      hit_d = 1'b1;
      case (PADDR_I)
         `ACS_ADDR_CFG0: rdata_d = cfg0_q;
         `ACS_ADDR_CFG1: rdata_d = cfg1_q;
         `ACS_ADDR_AVG: rdata_d = avg_q;
         `ACS_ADDR_STATUS: rdata_d = {3'h0, state_q, halted_q, foreground_complete_flag_q};
         `ACS_ADDR_PIN: rdata_d = pin_q;
         `ACS_ADDR_SOFT: rdata_d = soft_q;
         `ACS_ADDR_IRQ_STAT: rdata_d = {5'h00, irq_stat_q};
         `ACS_ADDR_IRQ_MASK: rdata_d = {5'h00, irq_mask_q};
         default: hit_d = 1'b0;
      endcase
   end

   // PREADY follows one cycle into the access phase, so every transfer has one wait
   always @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         pready_q <= PSEL_I & PENABLE_I & ~pready_q;
         if (PSEL_I & PENABLE_I & ~pready_q)
         begin
            pslverr_q <= ~hit_d;
            prdata_q <= PWRITE_I ? 32'h0000_0000 : {24'h00_0000, rdata_d};
         end
         else
         begin
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
         end
      end
   end

   // Block configuration; reserved bits keep what was written, so software restores defaults
   always @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         cfg0_q <= `ACS_RST_CFG0;
      end
      else if (wr_en && (PADDR_I == `ACS_ADDR_CFG0))
      begin
         cfg0_q <= PWDATA_I[7:0];
      end
   end

   // Offset reference choice; the engine sees a new value one cycle after the write
   always @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         cfg1_q <= `ACS_RST_CFG1;
      end
      else if (wr_en && (PADDR_I == `ACS_ADDR_CFG1))
      begin
         cfg1_q <= PWDATA_I[7:0];
      end
   end

   // Averaging depths for the offset and linearity routines
   always @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         avg_q <= `ACS_RST_AVG;
      end
      else if (wr_en && (PADDR_I == `ACS_ADDR_AVG))
      begin
         avg_q <= PWDATA_I[7:0];
      end
   end

   // Pin setup: status pin source and trigger source
   always @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         pin_q <= `ACS_RST_PIN;
      end
      else if (wr_en && (PADDR_I == `ACS_ADDR_PIN))
      begin
         pin_q <= PWDATA_I[7:0];
      end
   end

   // Software trigger; resets high so an unused trigger reads as asserted
   always @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         soft_q <= `ACS_RST_SOFT;
      end
      else if (wr_en && (PADDR_I == `ACS_ADDR_SOFT))
      begin
         soft_q <= PWDATA_I[7:0];
      end
   end

   // Interrupt mask; only the three event bits are stored
   always @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         irq_mask_q <= `ACS_RST_IRQ;
      end
      else if (wr_en && (PADDR_I == `ACS_ADDR_IRQ_MASK))
      begin
         irq_mask_q <= PWDATA_I[2:0];
      end
   end

   // Foreground flag: a completion in the same cycle as a new start still shows
   assign fg_set = FOREGROUND_COMPLETE_FLAG_I;
   always @*
   begin
      foreground_complete_flag_d = foreground_complete_flag_q;
      if (fg_set)
      begin
         foreground_complete_flag_d = 1'b1;
      end
      else if (FG_START_I)
      begin
         foreground_complete_flag_d = 1'b0;
      end
   end

   // Halted flag; with background off it also sets on foreground completion
   assign halt_set = BG_STOPPED_I | (~bg_en & FOREGROUND_COMPLETE_FLAG_I);
   always @*
   begin
      halted_d = halted_q;
      if (halt_set)
      begin
         halted_d = 1'b1;
      end
      else if (BG_RESUMED_I)
      begin
         halted_d = 1'b0;
      end
   end

   // Status capture; state code tracks the engine every cycle
   always @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         foreground_complete_flag_q <= 1'b0;
         halted_q <= 1'b0;
         state_q <= 3'h0;
         alarm_q <= 1'b0;
      end
      else
      begin
         foreground_complete_flag_q <= foreground_complete_flag_d;
         halted_q <= halted_d;
         state_q <= CAL_STATE_I;
         alarm_q <= ALARM_I;
      end
   end

   // Interrupt events are the flags' rising moments and the alarm's rising edge
   assign alarm_rise = ALARM_I & ~alarm_q;
   assign irq_evt = {alarm_rise, halt_set & ~halted_q, fg_set & ~foreground_complete_flag_q};

   // Sticky status, write one to clear; a new event beats the clear
   always @*
   begin
      irq_stat_d = irq_stat_q;
      if (wr_en && (PADDR_I == `ACS_ADDR_IRQ_STAT))
      begin
         irq_stat_d = irq_stat_q & ~PWDATA_I[2:0];
      end
      irq_stat_d = irq_stat_d | irq_evt;
   end

   always @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         irq_stat_q <= `ACS_RST_IRQ;
         irq_q <= 1'b0;
      end
      else
      begin
         irq_stat_q <= irq_stat_d;
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end

   // Status pin and trigger selection, registered so the pins never glitch
   always @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         status_pin_q <= 1'b0;
         trigger_q <= 1'b0;
      end
      else
      begin
         case (pin_q[`ACS_SEL_HI:`ACS_SEL_LO])
            `ACS_SEL_FG: status_pin_q <= foreground_complete_flag_q;
            `ACS_SEL_HALT: status_pin_q <= halted_q;
            `ACS_SEL_ALARM: status_pin_q <= alarm_q;
            `ACS_SEL_LOW: status_pin_q <= 1'b0;
            default: status_pin_q <= 1'b0;
         endcase
         if (pin_q[`ACS_BIT_TRIG_SEL])
         begin
            trigger_q <= trig_pin_sync;
         end
         else
         begin
            trigger_q <= soft_q[`ACS_BIT_SOFT_TRIG];
         end
      end
   end

   // Configuration fields straight from their registers to the engine
   assign OFFSET_REFERENCE_SELECT_O = cfg1_q[`ACS_BIT_OFFSET_REFERENCE_SELECT];
   assign OFFSET_AVERAGE_DEPTH_O = avg_q[`ACS_OFFSET_AVERAGE_DEPTH_HI:`ACS_OFFSET_AVERAGE_DEPTH_LO];
   assign LINEARITY_AVERAGE_DEPTH_O = avg_q[`ACS_LIN_AVG_HI:`ACS_LIN_AVG_LO];
   assign BACKGROUND_CAL_ENABLE_O = bg_en;
   assign CAL_TRIGGER_O = trigger_q;
   assign STATUS_OUTPUT_PIN_O = status_pin_q;
   assign IRQ_O = irq_q;
   assign PRDATA_O = prdata_q;
   assign PREADY_O = pready_q;
   assign PSLVERR_O = pslverr_q;

endmodule // acs_top

`default_nettype wire

/* File: acs_monitor.sv */
/* Checker for acs_top: APB timing and register-to-output relations.
   Assumes binding to acs_top and acs_defs.vh on the include path. */
`timescale 1ns/10ps
`default_nettype none
`include "acs_defs.vh"
module acs_monitor (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [`ACS_AW-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [3:0] PSTRB_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PREADY_O,
   input wire logic OFFSET_REFERENCE_SELECT_O,
   input wire logic [2:0] OFFSET_AVERAGE_DEPTH_O,
   input wire logic [2:0] LINEARITY_AVERAGE_DEPTH_O,
   input wire logic BACKGROUND_CAL_ENABLE_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   // Access phase waiting, then a single-cycle answer
   sequence s_access;
      PSEL_I && PENABLE_I && !PREADY_O;
   endsequence
   sequence s_answer;
      PREADY_O ##1 !PREADY_O;
   endsequence
   // Completing write to one address; strobe 0 must not count
   sequence s_wr(a);
      PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PSTRB_I[0] && PADDR_I == a;
   endsequence
   a_apb_one_wait: assert property (s_access |=> s_answer)
      else $error("pready not one cycle after access");
   a_cfg_reset_vals: assert property ($rose(RST_N_I) |-> OFFSET_AVERAGE_DEPTH_O == 3'h6
      && LINEARITY_AVERAGE_DEPTH_O == 3'h1 && !OFFSET_REFERENCE_SELECT_O && !BACKGROUND_CAL_ENABLE_O)
      else $error("configuration outputs wrong after reset");
   a_offset_reference_select_follows: assert property (s_wr(`ACS_ADDR_CFG1) |=>
      OFFSET_REFERENCE_SELECT_O == $past(PWDATA_I[2])) else $error("offset reference wrong");
   a_offset_average_depth_write: assert property (s_wr(`ACS_ADDR_AVG) |=>
      OFFSET_AVERAGE_DEPTH_O == $past(PWDATA_I[6:4])) else $error("offset depth wrong");
   a_lin_avg_write: assert property (s_wr(`ACS_ADDR_AVG) |=>
      LINEARITY_AVERAGE_DEPTH_O == $past(PWDATA_I[2:0])) else $error("linearity depth wrong");
   a_bg_en_write: assert property (s_wr(`ACS_ADDR_CFG0) |=>
      BACKGROUND_CAL_ENABLE_O == $past(PWDATA_I[1])) else $error("background enable wrong");
   a_avg_only_write: assert property ($changed(OFFSET_AVERAGE_DEPTH_O) |->
      $past(PREADY_O && PWRITE_I && PADDR_I == `ACS_ADDR_AVG)) else $error("depth moved alone");
   a_status_rsvd: assert property (PREADY_O && !PWRITE_I && PADDR_I == `ACS_ADDR_STATUS
      |-> PRDATA_O[31:5] == 27'h0) else $error("status reserved bits set");
endmodule // acs_monitor
bind acs_top acs_monitor u_acs_monitor (.CLK_I, .RST_N_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
   .PADDR_I, .PWDATA_I, .PSTRB_I, .PRDATA_O, .PREADY_O, .OFFSET_REFERENCE_SELECT_O,
   .OFFSET_AVERAGE_DEPTH_O, .LINEARITY_AVERAGE_DEPTH_O, .BACKGROUND_CAL_ENABLE_O);
`default_nettype wire

/* File: acs_tb.sv */
/* Self-checking bench for acs_top: APB tasks, engine pulses, directed tests.
   Assumes acs_top, acs_sync and acs_defs.vh are compiled alongside. */
`timescale 1ns/10ps
`default_nettype none
`include "acs_defs.vh"
`define CHK(g, e) begin #1; checked++; if ((g) !== (e)) begin error_cnt++; \
 $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
   logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, pin = 0, alarm = 0;
   logic [`ACS_AW-1:0] paddr = 0;
   logic [31:0] pwdata = 0, rdat;
   logic [3:0] pstrb = 0, ev = 0;
   logic [2:0] state = 0;
   logic rerr;
   logic [`ACS_AW-1:0] ra [5] = '{`ACS_ADDR_CFG0, `ACS_ADDR_CFG1, `ACS_ADDR_AVG,
      `ACS_ADDR_PIN, `ACS_ADDR_SOFT};
   logic [7:0] rv [5] = '{8'h01, 8'h01, 8'h61, 8'h00, 8'h01};
   logic [7:0] pe = 8'h52;
   int error_cnt = 0, checked = 0;
   wire [31:0] prdata;
   wire pready, pslverr, offset_reference_select, bg_en, trig, stat_pin, irq;
   wire [2:0] offset_average_depth, lin_avg;
   acs_top u_acs_top (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .FG_START_I(ev[0]),
      .FOREGROUND_COMPLETE_FLAG_I(ev[1]), .BG_STOPPED_I(ev[2]), .BG_RESUMED_I(ev[3]), .CAL_STATE_I(state),
      .ALARM_I(alarm), .TRIGGER_INPUT_PIN_I(pin), .OFFSET_REFERENCE_SELECT_O(offset_reference_select),
      .OFFSET_AVERAGE_DEPTH_O(offset_average_depth), .LINEARITY_AVERAGE_DEPTH_O(lin_avg),
      .BACKGROUND_CAL_ENABLE_O(bg_en), .CAL_TRIGGER_O(trig), .STATUS_OUTPUT_PIN_O(stat_pin),
      .IRQ_O(irq));
   // 25 MHz clock
   always #20 clk = ~clk;
   // One APB transfer; request held until pready is sampled high, the watchdog bounds the wait
   task apb(input logic w, input logic [`ACS_AW-1:0] a, input logic [7:0] d, input logic s);
      begin
         @(posedge clk);
         psel <= 1;
         pen <= 0;
         pwr <= w;
         paddr <= a;
         pwdata <= {24'h0, d};
         pstrb <= s ? 4'hf : 4'h0;
         @(posedge clk);
         pen <= 1;
         do
         begin
            @(posedge clk);
         end
         while (pready !== 1'b1);
         rdat = prdata;
         rerr = pslverr;
         psel <= 0;
         pen <= 0;
      end
   endtask
   task wr(input logic [`ACS_AW-1:0] a, input logic [7:0] d);
      apb(1, a, d, 1);
   endtask
   task rd(input logic [`ACS_AW-1:0] a);
      apb(0, a, 8'h00, 1);
   endtask
   // One-cycle engine pulse, then time for flags and pin to follow
   task ev_p(input logic [3:0] m);
      begin
         @(posedge clk);
         ev <= m;
         @(posedge clk);
         ev <= 0;
         repeat (3) @(posedge clk);
      end
   endtask
   task end_sim;
      begin
         $display("errors %0d checks %0d", error_cnt, checked);
         if (error_cnt == 0 && checked > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   // Watchdog: the directed sequence needs about 210 cycles
   initial
   begin
      #400000;
      error_cnt++;
      $display("[FAIL] %0t watchdog", $time);
      end_sim;
   end
   // Directed sequence
   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1;
      for (int i = 0; i < 5; i++)
      begin
         rd(ra[i]);
         `CHK(rdat[7:0], rv[i])
      end
      `CHK({offset_average_depth, lin_avg, bg_en, offset_reference_select}, 8'hc4)
      `CHK(trig, 1'b1)
      rd(`ACS_ADDR_STATUS);
      `CHK(rdat[7:0], 8'h00)
      wr(`ACS_ADDR_AVG, 8'h75);
      apb(1, `ACS_ADDR_AVG, 8'h00, 0);
      rd(`ACS_ADDR_AVG);
      `CHK(rdat[7:0], 8'h75)
      `CHK({offset_average_depth, lin_avg}, 6'h3d)
      @(posedge clk);
      state <= 3'h5;
      wr(`ACS_ADDR_STATUS, 8'hff);
      rd(`ACS_ADDR_STATUS);
      `CHK(rdat[7:0], 8'h14)
      wr(`ACS_ADDR_IRQ_MASK, 8'h01);
      ev_p(4'b0001);
      ev_p(4'b0010);
      `CHK(irq, 1'b1)
      rd(`ACS_ADDR_STATUS);
      `CHK(rdat[7:0], 8'h17)
      rd(`ACS_ADDR_IRQ_STAT);
      `CHK(rdat[7:0], 8'h03)
      wr(`ACS_ADDR_IRQ_STAT, 8'h01);
      wr(`ACS_ADDR_IRQ_MASK, 8'h00);
      `CHK(irq, 1'b0)
      ev_p(4'b0001);
      rd(`ACS_ADDR_STATUS);
      `CHK(rdat[0], 1'b0)
      // Background on first: the spare reference is only legal then
      wr(`ACS_ADDR_CFG0, 8'h03);
      wr(`ACS_ADDR_CFG1, 8'h05);
      `CHK({bg_en, offset_reference_select}, 2'b11)
      wr(`ACS_ADDR_CFG1, 8'h01);
      `CHK(offset_reference_select, 1'b0)
      ev_p(4'b1000);
      rd(`ACS_ADDR_STATUS);
      `CHK(rdat[1], 1'b0)
      ev_p(4'b0100);
      rd(`ACS_ADDR_STATUS);
      `CHK(rdat[1:0], 2'b10)
      `CHK(irq, 1'b0)
      // Two flag sets so every pin source except low is seen both high and low
      for (int p = 0; p < 8; p++)
      begin
         if (p == 4)
         begin
            ev_p(4'b1000);
            ev_p(4'b0010);
            alarm <= 1;
         end
         wr(`ACS_ADDR_PIN, {5'h0, p[1:0], 1'b0});
         repeat (2) @(posedge clk);
         `CHK(stat_pin, pe[p])
      end
      // Foreground, halted and alarm events have all set their sticky bits by now
      rd(`ACS_ADDR_IRQ_STAT);
      `CHK(rdat[7:0], 8'h07)
      wr(`ACS_ADDR_SOFT, 8'h00);
      pin <= 1;
      repeat (4) @(posedge clk);
      `CHK(trig, 1'b0)
      wr(`ACS_ADDR_PIN, 8'h01);
      repeat (4) @(posedge clk);
      `CHK(trig, 1'b1)
      @(posedge clk);
      pin <= 0;
      wr(`ACS_ADDR_SOFT, 8'h01);
      repeat (4) @(posedge clk);
      `CHK(trig, 1'b0)
      rd(12'h000);
      `CHK({rerr, rdat}, {1'b1, 32'h0})
      end_sim;
   end
endmodule // testbench
`default_nettype wire
